// ==== hw/dpc_port_ctrl.sv ====
// Top of the sample input ports, shared clock pins and serial control port
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "dpc_cfg.svh"
module dpc_port_ctrl #(
   parameter int PORT_W = 16
) (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Serial control port
   input  wire logic        serial_clk,
   input  wire logic        serial_select_pin,
   input  wire logic        hw_reset_pin,
   input  wire logic        serial_data_pin_i,
   output logic             serial_data_pin_o,
   output logic             serial_data_pin_oe,
   output logic             serial_out_pin_o,
   output logic             serial_out_pin_oe,
   // Clock and lock pins
   input  wire logic        pll_locked,
   input  wire logic        lock_or_rate_clock_pin_i,
   output logic             lock_or_rate_clock_pin_o,
   output logic             lock_or_rate_clock_pin_oe,
   // Sample ports
   input  wire logic [15:0] port_a_data,
   input  wire logic        channel_select,
   input  wire logic        port_b_bit14_i,
   output logic             port_b_bit14_o,
   output logic             port_b_bit14_oe,
   input  wire logic [13:0] port_b_low,
   output logic [15:0]      i_sample,
   output logic [15:0]      q_sample
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (PORT_W != 16) begin : g_bad_width
      $error("dpc_port_ctrl serves 16-bit ports only");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   dpc_pkg::dpc_core_state_t c_reg;
   dpc_pkg::dpc_core_state_t c_next;
   logic                     pll_en;
   logic                     two_port;
   logic                     aw_take;
   logic                     w_take;
   logic                     ar_take;
   logic [7:0]               rd_addr;

   dpc_ser_if ser ();

   // ----------------------------------------------------------------
   // Serial port on the link clock
   // ----------------------------------------------------------------
   dpc_serial_port u_serial (
      .serial_clk        (serial_clk),
      .serial_select_pin (serial_select_pin),
      .hw_reset_pin      (hw_reset_pin),
      .serial_data_pin_i (serial_data_pin_i),
      .ser               (ser.serial)
   );

   // ----------------------------------------------------------------
   // Mode decode and bus handshakes
   // ----------------------------------------------------------------
   // Mode bits and channel acceptance
   assign pll_en        = c_reg.mode[`DPC_MODE_PLL_BIT];
   assign two_port      = c_reg.mode[`DPC_MODE_TWOPORT_BIT];
   assign s_axi_awready = !c_reg.aw_held && !c_reg.bvalid;
   assign s_axi_wready  = !c_reg.w_held && !c_reg.bvalid;
   assign s_axi_arready = !c_reg.rvalid;
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;
   assign ar_take       = s_axi_arvalid && s_axi_arready;
   assign rd_addr       = {s_axi_araddr[7:2], 2'b00};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      c_next = c_reg;

      // Two-stage synchronisers for pins and serial config
      c_next.lock_s1 = pll_locked;
      c_next.lock_s2 = c_reg.lock_s1;
      c_next.dclk_s1 = lock_or_rate_clock_pin_i;
      c_next.dclk_s2 = c_reg.dclk_s1;
      c_next.cfg_s1  = {ser.clkcfg[`DPC_CLKCFG_SDOCLK_BIT],
                        ser.clkcfg[`DPC_CLKCFG_DCLK_BIT],
                        ser.ctrl[`DPC_CTRL_DIR_BIT]};
      c_next.cfg_s2  = c_reg.cfg_s1;
      c_next.pa_s1   = port_a_data;
      c_next.pa_s2   = c_reg.pa_s1;
      c_next.pb_s1   = {channel_select, port_b_bit14_i, port_b_low};
      c_next.pb_s2   = c_reg.pb_s1;

      // Half-rate divider: word clock for interleaved data
      c_next.div = ~c_reg.div;

      // Sample capture into I and Q registers
      if (two_port) begin
         c_next.i_word = c_reg.pa_s2;
         c_next.q_word = c_reg.pb_s2;
      end else if (c_reg.pb_s2[15]) begin
         c_next.i_word = c_reg.pa_s2;
      end else begin
         c_next.q_word = c_reg.pa_s2;
      end

      // Shared pin: lock state, else data-rate clock
      c_next.lock_out = pll_en ? c_reg.lock_s2 : c_reg.div;

      // Write address and data, taken in either order
      if (aw_take) begin
         c_next.aw_held = 1'b1;
         c_next.aw_addr = {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
         c_next.w_held  = 1'b1;
         c_next.w_mode  = s_axi_wdata[1:0];
         c_next.w_strb0 = s_axi_wstrb[0];
      end

      // Write performed once both halves are held
      if (c_reg.aw_held && c_reg.w_held) begin
         c_next.aw_held = 1'b0;
         c_next.w_held  = 1'b0;
         c_next.bvalid  = 1'b1;
         c_next.bresp   = `DPC_RESP_OKAY;
         case (c_reg.aw_addr)
            `DPC_AXI_MODE: begin
               if (c_reg.w_strb0) begin
                  c_next.mode = c_reg.w_mode;
               end
            end
            `DPC_AXI_STATUS, `DPC_AXI_ICAP, `DPC_AXI_QCAP: c_next.bresp = `DPC_RESP_OKAY;
            default: c_next.bresp = `DPC_RESP_SLVERR;
         endcase
      end else if (c_reg.bvalid && s_axi_bready) begin
         c_next.bvalid = 1'b0;
      end

      // Read answered in the cycle after the address
      if (ar_take) begin
         c_next.rvalid = 1'b1;
         c_next.rresp  = `DPC_RESP_OKAY;
         case (rd_addr)
            `DPC_AXI_MODE:   c_next.rdata = {30'h0, c_reg.mode};
            `DPC_AXI_STATUS: c_next.rdata = {27'h0, c_reg.cfg_s2, c_reg.dclk_s2,
                                             c_reg.lock_s2};
            `DPC_AXI_ICAP:   c_next.rdata = {16'h0, c_reg.i_word};
            `DPC_AXI_QCAP:   c_next.rdata = {16'h0, c_reg.q_word};
            default: begin
               c_next.rdata = 32'h0;
               c_next.rresp = `DPC_RESP_SLVERR;
            end
         endcase
      end else if (c_reg.rvalid && s_axi_rready) begin
         c_next.rvalid = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         c_reg      <= '0;
         c_reg.mode <= `DPC_MODE_RESET;
      end else begin
         c_reg <= c_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Bus answers
   assign s_axi_bvalid = c_reg.bvalid;
   assign s_axi_bresp  = c_reg.bresp;
   assign s_axi_rvalid = c_reg.rvalid;
   assign s_axi_rresp  = c_reg.rresp;
   assign s_axi_rdata  = c_reg.rdata;

   // Captured samples
   assign i_sample = c_reg.i_word;
   assign q_sample = c_reg.q_word;

   // Shared lock / rate clock pin
   assign lock_or_rate_clock_pin_o  = c_reg.lock_out;
   assign lock_or_rate_clock_pin_oe = pll_en || c_reg.cfg_s2[1];

   // Interleave clock out on port B bit 14
   assign port_b_bit14_o  = c_reg.div;
   assign port_b_bit14_oe = !pll_en && !two_port;

   // Serial data pin drives only during a read in output mode
   assign serial_data_pin_o  = ser.sdo_bit;
   assign serial_data_pin_oe = ser.ctrl[`DPC_CTRL_DIR_BIT] && ser.rd_active;

   // Separate output: read data or rate clock, off when data pin outputs
   assign serial_out_pin_o  = ser.clkcfg[`DPC_CLKCFG_SDOCLK_BIT] ? c_reg.div : ser.sdo_bit;
   assign serial_out_pin_oe = !ser.ctrl[`DPC_CTRL_DIR_BIT];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Lock state on shared pin
   a_lock_follow: assert property (@(posedge ref_clk) disable iff (reset)
      pll_en && $past(pll_en)
      |-> lock_or_rate_clock_pin_oe && lock_or_rate_clock_pin_o == $past(c_reg.lock_s2))
      else $error("lock pin does not follow loop lock");

   // Rate clock once settled out of reset
   a_rate_clk_dir: assert property (@(posedge ref_clk) disable iff (reset)
      !pll_en && !$past(pll_en) && !$past(pll_en, 2) && !$past(reset) && !$past(reset, 2)
      |-> lock_or_rate_clock_pin_oe == c_reg.cfg_s2[1]
          && lock_or_rate_clock_pin_o != $past(lock_or_rate_clock_pin_o))
      else $error("rate clock pin wrong");

   // I capture
   a_capture_i: assert property (@(posedge ref_clk) disable iff (reset)
      !two_port && c_reg.pb_s2[15] |=> i_sample == $past(c_reg.pa_s2) && $stable(q_sample))
      else $error("I capture wrong");

   // Q capture
   a_capture_q: assert property (@(posedge ref_clk) disable iff (reset)
      !two_port && !c_reg.pb_s2[15] |=> q_sample == $past(c_reg.pa_s2) && $stable(i_sample))
      else $error("Q capture wrong");

   // Two-port capture
   a_two_port_msb: assert property (@(posedge ref_clk) disable iff (reset)
      two_port |=> q_sample[15] == $past(c_reg.pb_s2[15]) && i_sample == $past(c_reg.pa_s2))
      else $error("two-port capture wrong");

   // Interleave clock toggles
   a_interleave_clk: assert property (@(posedge ref_clk) disable iff (reset)
      !reset && !pll_en && !two_port
      |-> port_b_bit14_oe ##1 port_b_bit14_o != $past(port_b_bit14_o))
      else $error("interleave clock missing");

   // Separate output released
   a_sdo_tristate: assert property (@(posedge ref_clk) disable iff (reset)
      ser.ctrl[7] |-> !serial_out_pin_oe)
      else $error("separate output driven while data pin outputs");

   // Rate clock on separate output
   a_sdo_rate_clk: assert property (@(posedge ref_clk) disable iff (reset)
      !ser.ctrl[7] && ser.clkcfg[1] |-> serial_out_pin_oe && serial_out_pin_o == c_reg.div)
      else $error("separate output not carrying rate clock");

   // Write answered
   a_write_answer: assert property (@(posedge ref_clk) disable iff (reset)
      c_reg.aw_held && c_reg.w_held |=> s_axi_bvalid && !c_reg.aw_held && !c_reg.w_held)
      else $error("write not answered");

   // Read answered
   a_read_answer: assert property (@(posedge ref_clk) disable iff (reset)
      ar_take && rd_addr == `DPC_AXI_MODE |=> s_axi_rvalid && s_axi_rdata[1:0] == $past(c_reg.mode))
      else $error("read not answered");

   // No read taken while answer stands
   a_read_refuse: assert property (@(posedge ref_clk) disable iff (reset)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during answer");

   // No write taken while answer stands
   a_write_refuse: assert property (@(posedge ref_clk) disable iff (reset)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during answer");

   // Write answer ends at handshake
   a_write_end: assert property (@(posedge ref_clk) disable iff (reset)
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");

   // Read answer ends at handshake
   a_read_end: assert property (@(posedge ref_clk) disable iff (reset)
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");

   // Unmapped read refused
   a_bad_read: assert property (@(posedge ref_clk) disable iff (reset)
      ar_take && rd_addr > `DPC_AXI_QCAP |=> s_axi_rresp == `DPC_RESP_SLVERR)
      else $error("unmapped read not refused");

   // Shared pin released as input
   a_lock_input: assert property (@(posedge ref_clk) disable iff (reset)
      !pll_en && !c_reg.cfg_s2[1] |-> !lock_or_rate_clock_pin_oe)
      else $error("shared pin driven as input");

   // Bit 14 released outside one-port
   a_b14_release: assert property (@(posedge ref_clk) disable iff (reset)
      pll_en || two_port |-> !port_b_bit14_oe)
      else $error("bit 14 driven outside one-port");

   // Data pin driven only as output
   a_sdio_dir: assert property (@(posedge ref_clk) disable iff (reset)
      serial_data_pin_oe |-> ser.ctrl[`DPC_CTRL_DIR_BIT])
      else $error("data pin driven as input");

endmodule // dpc_port_ctrl

// ==== hw/dpc_cfg.svh ====
// Offsets, field positions and reset values of the sample port and serial control block
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH

// ----------------------------------------------------------------
// Serial port register addresses and fields
// ----------------------------------------------------------------
`define DPC_SPI_CTRL_ADDR     5'h00
`define DPC_SPI_CLKCFG_ADDR   5'h02
`define DPC_CTRL_DIR_BIT      7
`define DPC_CTRL_SWRST_BIT    5
`define DPC_CTRL_RESET        8'h00
`define DPC_CLKCFG_DCLK_BIT   3
`define DPC_CLKCFG_SDOCLK_BIT 1
`define DPC_CLKCFG_RESET      8'h00
`define DPC_INSTR_RW_BIT      7
`define DPC_LAST_BIT          3'h7

// ----------------------------------------------------------------
// AXI4-Lite register byte offsets and fields
// ----------------------------------------------------------------
`define DPC_AXI_MODE          8'h00
`define DPC_AXI_STATUS        8'h04
`define DPC_AXI_ICAP          8'h08
`define DPC_AXI_QCAP          8'h0c
`define DPC_MODE_PLL_BIT      0
`define DPC_MODE_TWOPORT_BIT  1
`define DPC_MODE_RESET        2'h0
`define DPC_RESP_OKAY         2'h0
`define DPC_RESP_SLVERR       2'h2

`endif

// ==== hw/dpc_pkg.sv ====
// Types shared by the sample port and serial control block
package dpc_pkg;

   // ----------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {DPC_SER_INSTR, DPC_SER_DATA, DPC_SER_DONE} dpc_ser_phase_t;

   typedef struct packed {
      dpc_ser_phase_t phase;
      logic [2:0]     bit_cnt;
      logic [7:0]     shift;
      logic           read;
      logic [4:0]     addr;
      logic [7:0]     out_sh;
   } dpc_ser_state_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] clkcfg;
   } dpc_ser_regs_t;

   // ----------------------------------------------------------------
   // Core on the converter clock
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  mode;
      logic        lock_s1;
      logic        lock_s2;
      logic        dclk_s1;
      logic        dclk_s2;
      logic [2:0]  cfg_s1;
      logic [2:0]  cfg_s2;
      logic [15:0] pa_s1;
      logic [15:0] pa_s2;
      logic [15:0] pb_s1;
      logic [15:0] pb_s2;
      logic [15:0] i_word;
      logic [15:0] q_word;
      logic        div;
      logic        lock_out;
      logic        aw_held;
      logic [7:0]  aw_addr;
      logic        w_held;
      logic [1:0]  w_mode;
      logic        w_strb0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } dpc_core_state_t;

endpackage

// ==== hw/dpc_ser_if.sv ====
// Carrier between the serial port engine and the core
`timescale 1ns/10ps
interface dpc_ser_if;
   logic [7:0] ctrl;
   logic [7:0] clkcfg;
   logic       sdo_bit;
   logic       rd_active;
   modport serial (output ctrl, output clkcfg, output sdo_bit, output rd_active);
   modport core   (input ctrl, input clkcfg, input sdo_bit, input rd_active);
endinterface

// ==== hw/dpc_serial_port.sv ====
// Serial control port engine and its registers, on the serial clock
`timescale 1ns/10ps
`include "dpc_cfg.svh"
module dpc_serial_port (
   input  wire logic serial_clk,
   input  wire logic serial_select_pin,
   input  wire logic hw_reset_pin,
   input  wire logic serial_data_pin_i,
   dpc_ser_if.serial ser
);
   dpc_pkg::dpc_ser_state_t s_reg;
   dpc_pkg::dpc_ser_state_t s_next;
   dpc_pkg::dpc_ser_regs_t  r_reg;
   dpc_pkg::dpc_ser_regs_t  r_next;
   logic                    sdo_reg;
   logic [7:0]              byte_in;
   logic [7:0]              rd_data;
   logic                    wr_stb;

   // ----------------------------------------------------------------
   // Shift engine
   // ----------------------------------------------------------------
   // Byte completed by this rising edge, read data for its address
   always_comb begin
      byte_in = {s_reg.shift[6:0], serial_data_pin_i};
      case (byte_in[4:0])
         `DPC_SPI_CTRL_ADDR:   rd_data = r_reg.ctrl;
         `DPC_SPI_CLKCFG_ADDR: rd_data = r_reg.clkcfg;
         default:              rd_data = 8'h00;
      endcase
      wr_stb = (s_reg.phase == dpc_pkg::DPC_SER_DATA) && (s_reg.bit_cnt == `DPC_LAST_BIT)
               && !s_reg.read;
   end

   // Instruction byte, then one data byte, then idle until deselect
   always_comb begin
      s_next = s_reg;
      case (s_reg.phase)
         dpc_pkg::DPC_SER_INSTR: begin
            s_next.shift   = byte_in;
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            if (s_reg.bit_cnt == `DPC_LAST_BIT) begin
               s_next.phase  = dpc_pkg::DPC_SER_DATA;
               s_next.read   = byte_in[`DPC_INSTR_RW_BIT];
               s_next.addr   = byte_in[4:0];
               s_next.out_sh = rd_data;
            end
         end
         dpc_pkg::DPC_SER_DATA: begin
            s_next.shift   = byte_in;
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            s_next.out_sh  = {s_reg.out_sh[6:0], 1'b0};
            if (s_reg.bit_cnt == `DPC_LAST_BIT) begin
               s_next.phase = dpc_pkg::DPC_SER_DONE;
            end
         end
         default: s_next = s_reg;
      endcase
   end

   // Deselect clears the engine at once, even between clock edges
   always_ff @(posedge serial_clk or posedge serial_select_pin) begin
      if (serial_select_pin) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Read bits leave on the falling edge
   always_ff @(negedge serial_clk or posedge serial_select_pin) begin
      if (serial_select_pin) begin
         sdo_reg <= 1'b0;
      end else begin
         sdo_reg <= s_reg.out_sh[7];
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Write decode, soft reset spares the control byte
   always_comb begin
      r_next = r_reg;
      if (wr_stb && (s_reg.addr == `DPC_SPI_CTRL_ADDR)) begin
         r_next.ctrl = byte_in;
         r_next.ctrl[`DPC_CTRL_SWRST_BIT] = 1'b0;
         if (byte_in[`DPC_CTRL_SWRST_BIT]) begin
            r_next.clkcfg = `DPC_CLKCFG_RESET;
         end
      end else if (wr_stb && (s_reg.addr == `DPC_SPI_CLKCFG_ADDR)) begin
         r_next.clkcfg = byte_in;
      end
   end

   // Hardware reset pin returns every register to default
   always_ff @(posedge serial_clk or posedge hw_reset_pin) begin
      if (hw_reset_pin) begin
         r_reg <= {`DPC_CTRL_RESET, `DPC_CLKCFG_RESET};
      end else begin
         r_reg <= r_next;
      end
   end

   assign ser.ctrl      = r_reg.ctrl;
   assign ser.clkcfg    = r_reg.clkcfg;
   assign ser.sdo_bit   = sdo_reg;
   assign ser.rd_active = (s_reg.phase == dpc_pkg::DPC_SER_DATA) && s_reg.read;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_sclk_sample: assert property (@(posedge serial_clk) disable iff (serial_select_pin)
      s_reg.phase != dpc_pkg::DPC_SER_DONE |=> s_reg.shift[0] == $past(serial_data_pin_i))
      else $error("serial bit not taken on rising edge");
   a_fall_launch: assert property (@(posedge serial_clk) disable iff (serial_select_pin)
      ser.rd_active && $past(ser.rd_active) |-> sdo_reg == s_reg.out_sh[7])
      else $error("read bit not launched on falling edge");
   a_select_clear: assert property (@(negedge serial_select_pin)
      s_reg.phase == dpc_pkg::DPC_SER_INSTR && s_reg.bit_cnt == 3'h0)
      else $error("engine not cleared by deselect");
   a_hw_reset: assert property (@(negedge hw_reset_pin)
      r_reg.ctrl == `DPC_CTRL_RESET && r_reg.clkcfg == `DPC_CLKCFG_RESET)
      else $error("registers not at default during reset pin");
   a_soft_reset: assert property (@(posedge serial_clk) disable iff (hw_reset_pin)
      wr_stb && s_reg.addr == `DPC_SPI_CTRL_ADDR && byte_in[`DPC_CTRL_SWRST_BIT]
      |=> r_reg.clkcfg == `DPC_CLKCFG_RESET && r_reg.ctrl[7] == $past(byte_in[7]))
      else $error("soft reset wrong");
endmodule // dpc_serial_port

// ==== verif/dpc_host_model.sv ====
// Serial host controller model for the control port
`timescale 1ns/10ps
module dpc_host_model (
   output logic      sclk,
   output logic      sel,
   output logic      sdi,
   input  wire logic pin,
   input  wire logic separate_serial_output
);
   // Idle: clock still, deselected
   initial begin
      sclk = 1'b0;
      sel  = 1'b1;
      sdi  = 1'b0;
   end
   // Frame of n bits, instruction then data, MSB first
   task automatic xfer(input logic [7:0] ins, input logic [7:0] dat, input int n,
                       input bit alt, output logic [7:0] rx);
      logic [15:0] w;
      w = {ins, dat};
      rx = 8'h00;
      sel = 1'b0;
      #62.5;
      for (int i = 15; i > 15 - n; i--) begin
         sdi = (ins[7] && i < 8) ? ~sdi : w[i];
         #62.5;
         if (i < 8) rx[i] = alt ? separate_serial_output : pin;
         sclk = 1'b1;
         #62.5 sclk = 1'b0;
      end
      #62.5 sel = 1'b1;
      #125;
   endtask
endmodule // dpc_host_model

// ==== verif/testbench.sv ====
// Self-checking bench for the sample port and serial control block
`timescale 1ns/10ps
`include "dpc_cfg.svh"
module testbench;
   logic        ref_clk, reset = 1'b1, hrst = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [31:0] wd = 32'h0, rd, d1, d2, rnd;
   logic [3:0]  ws = 4'hf;
   logic        awr, wrd, bv, arr, rv, sclk, ssel, host_sdi, sdo_o, sdo_oe, so_o, so_oe;
   logic [1:0]  bre, rre;
   logic        pll = 1'b0, lkd = 1'b1, sel = 1'b0, b14d = 1'b0, lk_o, lk_oe, b14_o, b14_oe, t;
   logic [15:0] pa = 16'h0, isamp, qsamp;
   logic [13:0] pbl = 14'h0;
   logic [7:0]  rx;
   logic [31:0] expq[$];
   int          n_errors = 0, n_checks = 0, cyc = 0;
   wire         sdio = sdo_oe ? sdo_o : host_sdi;
   wire         lk_line = lk_oe ? lk_o : lkd;
   wire         b14_line = b14_oe ? b14_o : b14d;
   wire         so_line = so_oe ? so_o : ~so_o;

   dpc_port_ctrl #(.PORT_W(16)) dpc_port_ctrl_i (
      .ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rry), .serial_clk(sclk),
      .serial_select_pin(ssel), .hw_reset_pin(hrst), .serial_data_pin_i(sdio),
      .serial_data_pin_o(sdo_o), .serial_data_pin_oe(sdo_oe), .serial_out_pin_o(so_o),
      .serial_out_pin_oe(so_oe), .pll_locked(pll), .lock_or_rate_clock_pin_i(lk_line),
      .lock_or_rate_clock_pin_o(lk_o), .lock_or_rate_clock_pin_oe(lk_oe),
      .port_a_data(pa), .channel_select(sel), .port_b_bit14_i(b14_line),
      .port_b_bit14_o(b14_o), .port_b_bit14_oe(b14_oe), .port_b_low(pbl),
      .i_sample(isamp), .q_sample(qsamp));

   dpc_host_model dpc_host_model_i (
      .sclk(sclk), .sel(ssel), .sdi(host_sdi), .pin(sdio), .separate_serial_output(so_line));

   // Clock, 10 ns period
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Register write, both halves offered together
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!(awr && wrd)) tick(1);
      @(posedge ref_clk);
      awv <= 1'b0;
      wv <= 1'b0;
      #1 while (!bv) tick(1);
      check(bre, `DPC_RESP_OKAY);
      @(posedge ref_clk);
      bry <= 1'b0;
      #1;
   endtask

   // Register read, expected data noted for the monitor
   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      ara <= a;
      arv <= 1'b1;
      while (!arr) tick(1);
      @(posedge ref_clk);
      arv <= 1'b0;
      rry <= 1'b1;
      expq.push_back(e);
      #1 while (!rv) tick(1);
      check(rre, r);
      @(posedge ref_clk);
      rry <= 1'b0;
      #1;
   endtask

   // Read data monitor
   always @(negedge ref_clk)
      if (rv && rry) check(rd, expq.pop_front());

   // Hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // Main sequence
   initial begin
      rnd = $urandom(32'hc1c4a5c2);
      hrst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      hrst <= 1'b0;
      tick(4);
      check(sdo_oe, 0);
      check(so_oe, 1);
      axr(`DPC_AXI_STATUS, 32'h2, `DPC_RESP_OKAY);
      repeat (3) begin
         d1 = $urandom;
         d2 = $urandom;
         pa <= d1[15:0];
         sel <= 1'b1;
         tick(4);
         pa <= d2[15:0];
         sel <= 1'b0;
         tick(4);
         check(isamp, d1[15:0]);
         check(qsamp, d2[15:0]);
      end
      axr(`DPC_AXI_ICAP, {16'h0, d1[15:0]}, `DPC_RESP_OKAY);
      check(b14_oe, 1);
      t = b14_o;
      tick(1);
      check(b14_o ^ t, 1);
      axw(`DPC_AXI_MODE, 32'h2);
      d1 = $urandom;
      pa <= d1[15:0];
      sel <= d1[16];
      b14d <= d1[17];
      pbl <= d1[31:18];
      tick(4);
      check(isamp, d1[15:0]);
      check(qsamp, {d1[16], d1[17], d1[31:18]});
      check(b14_oe, 0);
      axw(`DPC_AXI_MODE, 32'h1);
      pll <= 1'b1;
      tick(6);
      check({lk_oe, lk_o}, 2'h3);
      axr(`DPC_AXI_STATUS, 32'h3, `DPC_RESP_OKAY);
      pll <= 1'b0;
      tick(6);
      check(lk_o, 0);
      axw(`DPC_AXI_MODE, 32'h0);
      axr(8'h10, 32'h0, `DPC_RESP_SLVERR);
      dpc_host_model_i.xfer(8'h02, 8'h08, 16, 1'b0, rx);
      tick(5);
      t = lk_o;
      tick(1);
      check({lk_oe, lk_o ^ t}, 2'h3);
      dpc_host_model_i.xfer(8'h82, 8'h00, 16, 1'b1, rx);
      check(rx, 8'h08);
      dpc_host_model_i.xfer(8'h00, 8'h80, 16, 1'b0, rx);
      tick(5);
      check({so_oe, sdo_oe}, 2'h0);
      dpc_host_model_i.xfer(8'h80, 8'h00, 4, 1'b0, rx);
      dpc_host_model_i.xfer(8'h80, 8'h00, 16, 1'b0, rx);
      check(rx, 8'h80);
      dpc_host_model_i.xfer(8'h00, 8'ha0, 16, 1'b0, rx);
      dpc_host_model_i.xfer(8'h82, 8'h00, 16, 1'b0, rx);
      check(rx, 8'h00);
      dpc_host_model_i.xfer(8'h80, 8'h00, 16, 1'b0, rx);
      check(rx, 8'h80);
      dpc_host_model_i.xfer(8'h00, 8'h00, 16, 1'b0, rx);
      dpc_host_model_i.xfer(8'h02, 8'h02, 16, 1'b0, rx);
      tick(5);
      t = so_o;
      tick(1);
      check({so_oe, so_o ^ t}, 2'h3);
      dpc_host_model_i.xfer(8'h00, 8'h80, 16, 1'b0, rx);
      hrst <= 1'b1;
      tick(2);
      hrst <= 1'b0;
      tick(5);
      check({sdo_oe, so_oe}, 2'h1);
      axr(`DPC_AXI_STATUS, 32'h2, `DPC_RESP_OKAY);
      report_and_stop();
   end
endmodule // testbench
